// [rtl/srcs_top.sv]
// SDLC receive channel: control registers, receiver and DMA hand-off
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
// Summary of operation
// - Receive control written disabled with hunt; receiver then hunts.
// - With auto enables, bits are taken only while carrier detect high.
// - First non-flag byte must match secondary or global address.
// - Secondary address register holds the host-loaded station address.
// - Flag pattern register recognises opening and closing flags.
// - First-character mode: address byte to CPU, rest through DMA.
// - Vector and status-affects-vector only in the second channel.
// - Arm command re-enables the first-character interrupt.
// - Receive interrupts only after opening flag and matching address.
// - Control/data and channel select inputs address the device.
// - Receiver returns to hunt only on explicit host command.
module srcs_top
  import srcs_pkg::*;
#(
  parameter logic CHAN_ID = 1'b1,
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [SRCS_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rx_clk,
  input wire logic rx_data,
  input wire logic dcd,
  input wire logic dma_ack,
  output logic dma_req,
  output logic [7:0] dma_data,
  output logic irq,
  output logic dtr
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  // Fewer than two stages would let a metastable level reach the logic
  if (SYNC_STAGES < 2) begin : g_sync_check
    $error("SYNC_STAGES must be at least 2");
  end

  // Vector hardware exists only in the second channel
  localparam logic HAS_VEC = CHAN_ID;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] sync_r [SYNC_STAGES];
  logic clk_prev_r;
  logic dcd_prev_r;
  logic clk_s, dat_s, dcd_s;

  // Pin levels pass two or more flops before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_r[i] <= '0;
      end
      clk_prev_r <= 1'b0;
      dcd_prev_r <= 1'b0;
    end else begin
      sync_r[0] <= {rx_clk, rx_data, dcd};
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
      clk_prev_r <= clk_s;
      dcd_prev_r <= dcd_s;
    end
  end

  assign {clk_s, dat_s, dcd_s} = sync_r[SYNC_STAGES-1];

  // ****************************************************************
  // Control and receive state
  // ****************************************************************
  logic [2:0] ptr_r, ptr_nxt;
  logic [7:0] int_ctl_r, int_ctl_nxt;
  logic [7:0] vec_r, vec_nxt;
  logic [7:0] rx_ctl_r, rx_ctl_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] tx_ctl_r, tx_ctl_nxt;
  logic [7:0] sec_adr_r, sec_adr_nxt;
  logic [7:0] flag_pat_r, flag_pat_nxt;
  logic armed_r, armed_nxt;
  srcs_rx_state_t st_r, st_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] shf_r, shf_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic avail_r, avail_nxt;
  logic dma_req_r, dma_req_nxt;
  logic [7:0] dma_data_r, dma_data_nxt;
  logic [SRCS_IRQ_W-1:0] ist_r, ist_nxt;
  logic [SRCS_IRQ_W-1:0] ien_r, ien_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  srcs_bit_if bif ();

  srcs_deframer u_dfr (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(bif)
  );

  logic own_ch, aux, ctl_port;
  logic gate, chan_rst, hunt_cmd, first_mode;
  logic [2:0] cmd;
  logic [3:0] nbits;
  logic [7:0] shf_in, chr, vec_out;
  logic [2:0] cause;
  logic [SRCS_IRQ_W-1:0] ev, iclr;

  // Bus decode and bit gating
  always_comb begin
    own_ch = (addr[SRCS_ADDR_CH] == CHAN_ID);
    aux = addr[SRCS_ADDR_AUX];
    ctl_port = addr[SRCS_ADDR_CD];
    cmd = wdata[SRCS_CMD_LSB +: 3];
    // Receiver runs only in SDLC format, enabled, and with carrier if asked
    gate = rx_ctl_r[SRCS_RXC_EN]
      && (mode_r[SRCS_MODE_FMT +: 2] == SRCS_FMT_SDLC)
      && (!rx_ctl_r[SRCS_RXC_AUTO] || dcd_s);
    bif.bit_stb = gate && clk_s && !clk_prev_r;
    bif.bit_val = dat_s;
    bif.pattern = flag_pat_r;
    first_mode = (int_ctl_r[SRCS_INT_MODE +: 2] == SRCS_RXI_FIRST);
    nbits = srcs_char_bits(rx_ctl_r[SRCS_RXC_LEN +: 2]);
  end

  // Main next-state logic: registers, receiver, interrupts, read data
  always_comb begin
    ptr_nxt = ptr_r;
    int_ctl_nxt = int_ctl_r;
    vec_nxt = vec_r;
    rx_ctl_nxt = rx_ctl_r;
    mode_nxt = mode_r;
    tx_ctl_nxt = tx_ctl_r;
    sec_adr_nxt = sec_adr_r;
    flag_pat_nxt = flag_pat_r;
    armed_nxt = armed_r;
    st_nxt = st_r;
    bitcnt_nxt = bitcnt_r;
    shf_nxt = shf_r;
    rxd_nxt = rxd_r;
    avail_nxt = avail_r;
    dma_req_nxt = dma_req_r;
    dma_data_nxt = dma_data_r;
    ien_nxt = ien_r;
    rdata_nxt = SRCS_RST_BYTE;
    chan_rst = 1'b0;
    hunt_cmd = 1'b0;
    ev = '0;
    iclr = '0;
    shf_in = {bif.data_bit, shf_r[7:1]};
    chr = shf_in >> (SRCS_CHAR_MAX - nbits);

    // Status-affects-vector puts the highest pending cause in the vector
    if (ist_r[SRCS_EV_OVRN] || ist_r[SRCS_EV_EOF]) begin
      cause = SRCS_CAUSE_SPEC;
    end else if (ist_r[SRCS_EV_FIRST]) begin
      cause = SRCS_CAUSE_RX;
    end else if (ist_r[SRCS_EV_DCD]) begin
      cause = SRCS_CAUSE_EXT;
    end else begin
      cause = SRCS_CAUSE_SPEC;
    end
    vec_out = vec_r;
    if (int_ctl_r[SRCS_INT_SAV]) begin
      vec_out[SRCS_VEC_CAUSE +: 3] = cause;
    end

    // ---- Register writes ----
    if (wr && own_ch && !aux && ctl_port) begin
      if (ptr_r == SRCS_PTR_CMD) begin
        ptr_nxt = wdata[2:0];
        if (cmd == SRCS_CMD_CHAN_RST) begin
          chan_rst = 1'b1;
        end else if (cmd == SRCS_CMD_ARM_NEXT) begin
          armed_nxt = 1'b1;
        end else if (cmd == SRCS_CMD_RST_EXT) begin
          iclr[SRCS_EV_DCD] = 1'b1;
        end
      end else begin
        ptr_nxt = SRCS_PTR_CMD;
        case (ptr_r)
          SRCS_PTR_INT: int_ctl_nxt = wdata;
          SRCS_PTR_VEC: vec_nxt = HAS_VEC ? wdata : vec_r;
          SRCS_PTR_RXC: begin
            rx_ctl_nxt = wdata;
            hunt_cmd = wdata[SRCS_RXC_HUNT];
          end
          SRCS_PTR_MODE: mode_nxt = wdata;
          SRCS_PTR_TXC: tx_ctl_nxt = wdata;
          SRCS_PTR_SADR: sec_adr_nxt = wdata;
          SRCS_PTR_FLAG: flag_pat_nxt = wdata;
          default: ptr_nxt = SRCS_PTR_CMD;
        endcase
      end
    end
    if (wr && aux && addr[1:0] == SRCS_AUX_CLEAR) begin
      iclr = iclr | wdata[SRCS_IRQ_W-1:0];
    end
    if (wr && aux && addr[1:0] == SRCS_AUX_ENABLE) begin
      ien_nxt = wdata[SRCS_IRQ_W-1:0];
    end

    // ---- Register reads, data one cycle later ----
    if (rd && aux) begin
      if (addr[1:0] == SRCS_AUX_STATUS) begin
        rdata_nxt[SRCS_IRQ_W-1:0] = ist_r;
      end else if (addr[1:0] == SRCS_AUX_ENABLE) begin
        rdata_nxt[SRCS_IRQ_W-1:0] = ien_r;
      end
    end else if (rd && own_ch && !ctl_port) begin
      rdata_nxt = rxd_r;
      avail_nxt = 1'b0;
    end else if (rd && own_ch) begin
      ptr_nxt = SRCS_PTR_CMD;
      if (HAS_VEC && ptr_r == SRCS_PTR_VEC) begin
        rdata_nxt = vec_out;
      end else begin
        rdata_nxt[SRCS_ST_AVAIL] = avail_r;
        rdata_nxt[SRCS_ST_IRQ] = irq_r;
        rdata_nxt[SRCS_ST_DCD] = dcd_s;
        rdata_nxt[SRCS_ST_HUNT] = (st_r == RX_HUNT);
        rdata_nxt[SRCS_ST_DMA] = dma_req_r;
      end
    end
    if (dma_ack) begin
      dma_req_nxt = 1'b0;
    end

    // ---- Receiver sequencing; hunt only by command ----
    if (bif.flag_stb) begin
      bitcnt_nxt = '0;
      if (st_r == RX_DATA) begin
        ev[SRCS_EV_EOF] = 1'b1;
      end
      st_nxt = RX_OPEN;
    end else if (bif.abort_stb) begin
      bitcnt_nxt = '0;
      if (st_r != RX_HUNT) begin
        st_nxt = RX_SKIP;
      end
    end else if (bif.data_stb && (st_r == RX_OPEN || st_r == RX_DATA)) begin
      shf_nxt = shf_in;
      if (bitcnt_r == nbits - 4'h1) begin
        bitcnt_nxt = '0;
        if (st_r == RX_OPEN) begin
          // Address byte: match programmed or global station address
          if (!rx_ctl_r[SRCS_RXC_ASRCH] || chr == sec_adr_r
              || chr == SRCS_GLOBAL_ADDR) begin
            st_nxt = RX_DATA;
            ev[SRCS_EV_OVRN] = avail_nxt;
            rxd_nxt = chr;
            avail_nxt = 1'b1;
            if (first_mode && armed_r) begin
              ev[SRCS_EV_FIRST] = 1'b1;
              armed_nxt = 1'b0;
            end
          end else begin
            st_nxt = RX_SKIP;
          end
        end else if (first_mode) begin
          // Later bytes go to the DMA side, never to the CPU port
          ev[SRCS_EV_OVRN] = dma_req_nxt;
          dma_data_nxt = chr;
          dma_req_nxt = 1'b1;
        end else begin
          ev[SRCS_EV_OVRN] = avail_nxt;
          rxd_nxt = chr;
          avail_nxt = 1'b1;
        end
      end else begin
        bitcnt_nxt = bitcnt_r + 4'h1;
      end
    end
    if (hunt_cmd) begin
      st_nxt = RX_HUNT;
      bitcnt_nxt = '0;
    end

    // Carrier change is an external status event
    ev[SRCS_EV_DCD] = ev[SRCS_EV_DCD] | (dcd_s ^ dcd_prev_r);
    // Sticky bits: a new event wins over a clear in the same cycle
    ist_nxt = (ist_r & ~iclr) | ev;
    irq_nxt = |(ist_nxt & ien_nxt);

    // Channel reset returns every control field to its default
    if (chan_rst) begin
      ptr_nxt = SRCS_PTR_CMD;
      int_ctl_nxt = SRCS_RST_BYTE;
      vec_nxt = SRCS_RST_BYTE;
      rx_ctl_nxt = SRCS_RST_BYTE;
      mode_nxt = SRCS_RST_BYTE;
      tx_ctl_nxt = SRCS_RST_BYTE;
      sec_adr_nxt = SRCS_RST_BYTE;
      flag_pat_nxt = SRCS_RST_FLAG;
      armed_nxt = 1'b1;
      st_nxt = RX_HUNT;
      bitcnt_nxt = '0;
      avail_nxt = 1'b0;
      dma_req_nxt = 1'b0;
      ist_nxt = '0;
      ien_nxt = '0;
      irq_nxt = 1'b0;
    end
  end

  // Deframer is flushed on hunt and on channel reset
  assign bif.clr = chan_rst || hunt_cmd;

  // Registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_r <= SRCS_PTR_CMD;
      int_ctl_r <= SRCS_RST_BYTE;
      vec_r <= SRCS_RST_BYTE;
      rx_ctl_r <= SRCS_RST_BYTE;
      mode_r <= SRCS_RST_BYTE;
      tx_ctl_r <= SRCS_RST_BYTE;
      sec_adr_r <= SRCS_RST_BYTE;
      flag_pat_r <= SRCS_RST_FLAG;
      armed_r <= 1'b1;
      st_r <= RX_HUNT;
      bitcnt_r <= '0;
      shf_r <= SRCS_RST_BYTE;
      rxd_r <= SRCS_RST_BYTE;
      avail_r <= 1'b0;
      dma_req_r <= 1'b0;
      dma_data_r <= SRCS_RST_BYTE;
      ist_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= SRCS_RST_BYTE;
    end else begin
      ptr_r <= ptr_nxt;
      int_ctl_r <= int_ctl_nxt;
      vec_r <= vec_nxt;
      rx_ctl_r <= rx_ctl_nxt;
      mode_r <= mode_nxt;
      tx_ctl_r <= tx_ctl_nxt;
      sec_adr_r <= sec_adr_nxt;
      flag_pat_r <= flag_pat_nxt;
      armed_r <= armed_nxt;
      st_r <= st_nxt;
      bitcnt_r <= bitcnt_nxt;
      shf_r <= shf_nxt;
      rxd_r <= rxd_nxt;
      avail_r <= avail_nxt;
      dma_req_r <= dma_req_nxt;
      dma_data_r <= dma_data_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flops
  assign rdata = rdata_r;
  assign dma_req = dma_req_r;
  assign dma_data = dma_data_r;
  assign irq = irq_r;
  assign dtr = tx_ctl_r[SRCS_TXC_DTR];

endmodule // srcs_top

// [shared/srcs_pkg.sv]
// Constants, field layouts and types shared by the SDLC receive channel
package srcs_pkg;

  // ****************************************************************
  // Bus addressing
  // ****************************************************************
  localparam int SRCS_ADDR_W = 3;
  localparam int SRCS_ADDR_CD = 0;      // 0 data port, 1 command/status
  localparam int SRCS_ADDR_CH = 1;      // 0 first channel, 1 second
  localparam int SRCS_ADDR_AUX = 2;     // 1 selects the interrupt bank
  localparam logic [1:0] SRCS_AUX_STATUS = 2'h0;
  localparam logic [1:0] SRCS_AUX_CLEAR = 2'h1;
  localparam logic [1:0] SRCS_AUX_ENABLE = 2'h2;

  // ****************************************************************
  // Register pointer values and commands
  // ****************************************************************
  localparam logic [2:0] SRCS_PTR_CMD = 3'h0;
  localparam logic [2:0] SRCS_PTR_INT = 3'h1;
  localparam logic [2:0] SRCS_PTR_VEC = 3'h2;
  localparam logic [2:0] SRCS_PTR_RXC = 3'h3;
  localparam logic [2:0] SRCS_PTR_MODE = 3'h4;
  localparam logic [2:0] SRCS_PTR_TXC = 3'h5;
  localparam logic [2:0] SRCS_PTR_SADR = 3'h6;
  localparam logic [2:0] SRCS_PTR_FLAG = 3'h7;
  localparam int SRCS_CMD_LSB = 3;
  localparam logic [2:0] SRCS_CMD_NULL = 3'h0;
  localparam logic [2:0] SRCS_CMD_RST_EXT = 3'h2;
  localparam logic [2:0] SRCS_CMD_CHAN_RST = 3'h3;
  localparam logic [2:0] SRCS_CMD_ARM_NEXT = 3'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SRCS_RXC_EN = 0;
  localparam int SRCS_RXC_ASRCH = 2;
  localparam int SRCS_RXC_CRC = 3;
  localparam int SRCS_RXC_HUNT = 4;
  localparam int SRCS_RXC_AUTO = 5;
  localparam int SRCS_RXC_LEN = 6;      // two bits
  localparam int SRCS_INT_EXT = 0;
  localparam int SRCS_INT_SAV = 2;
  localparam int SRCS_INT_MODE = 3;     // two bits
  localparam logic [1:0] SRCS_RXI_FIRST = 2'h1;
  localparam int SRCS_MODE_FMT = 4;     // two bits
  localparam logic [1:0] SRCS_FMT_SDLC = 2'h2;
  localparam int SRCS_TXC_DTR = 7;
  localparam int SRCS_VEC_CAUSE = 1;    // three bits

  // Status byte bits
  localparam int SRCS_ST_AVAIL = 0;
  localparam int SRCS_ST_IRQ = 1;
  localparam int SRCS_ST_DCD = 3;
  localparam int SRCS_ST_HUNT = 4;
  localparam int SRCS_ST_DMA = 5;

  // Sticky interrupt bits
  localparam int SRCS_IRQ_W = 4;
  localparam int SRCS_EV_FIRST = 0;
  localparam int SRCS_EV_OVRN = 1;
  localparam int SRCS_EV_DCD = 2;
  localparam int SRCS_EV_EOF = 3;

  // Vector cause codes
  localparam logic [2:0] SRCS_CAUSE_EXT = 3'h1;
  localparam logic [2:0] SRCS_CAUSE_RX = 3'h2;
  localparam logic [2:0] SRCS_CAUSE_SPEC = 3'h3;

  // ****************************************************************
  // Reset values and fixed patterns
  // ****************************************************************
  localparam logic [7:0] SRCS_RST_BYTE = 8'h00;
  localparam logic [7:0] SRCS_RST_FLAG = 8'h7E;
  localparam logic [7:0] SRCS_GLOBAL_ADDR = 8'hFF;
  localparam logic [3:0] SRCS_CHAR_MAX = 4'h8;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_OPEN,
    RX_DATA,
    RX_SKIP
  } srcs_rx_state_t;

  // Character length code to bits per character
  function automatic logic [3:0] srcs_char_bits(input logic [1:0] code);
    case (code)
      2'h0: srcs_char_bits = 4'h5;
      2'h1: srcs_char_bits = 4'h7;
      2'h2: srcs_char_bits = 4'h6;
      default: srcs_char_bits = 4'h8;
    endcase
  endfunction

endpackage

// [shared/srcs_bit_if.sv]
// Bit-level link between the channel control and the deframer
`timescale 1ns/1ns
interface srcs_bit_if;
  logic bit_stb;
  logic bit_val;
  logic clr;
  logic [7:0] pattern;
  logic data_stb;
  logic data_bit;
  logic flag_stb;
  logic abort_stb;

  modport ctl (
    output bit_stb,
    output bit_val,
    output clr,
    output pattern,
    input data_stb,
    input data_bit,
    input flag_stb,
    input abort_stb
  );

  modport dfr (
    input bit_stb,
    input bit_val,
    input clr,
    input pattern,
    output data_stb,
    output data_bit,
    output flag_stb,
    output abort_stb
  );
endinterface

// [rtl/srcs_deframer.sv]
// Flag detection, zero deletion and abort detection on the raw bit stream
`timescale 1ns/1ns
module srcs_deframer
  import srcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  srcs_bit_if.dfr bus
);

  logic [7:0] raw_r, raw_nxt;
  logic [2:0] ones_r, ones_nxt;
  logic [6:0] q_r, q_nxt;
  logic [2:0] qn_r, qn_nxt;
  logic [7:0] win;

  // Seven-bit delay keeps the leading part of a closing flag out of data
  always_comb begin
    raw_nxt = raw_r;
    ones_nxt = ones_r;
    q_nxt = q_r;
    qn_nxt = qn_r;
    win = {bus.bit_val, raw_r[7:1]};
    bus.data_stb = 1'b0;
    bus.data_bit = q_r[0];
    bus.flag_stb = 1'b0;
    bus.abort_stb = 1'b0;
    if (bus.clr) begin
      raw_nxt = '0;
      ones_nxt = '0;
      qn_nxt = '0;
    end else if (bus.bit_stb) begin
      raw_nxt = win;
      if (bus.bit_val) begin
        ones_nxt = (ones_r == 3'h7) ? ones_r : ones_r + 3'h1;
      end else begin
        ones_nxt = '0;
      end
      if (!bus.bit_val && win == bus.pattern) begin
        bus.flag_stb = 1'b1;
        qn_nxt = '0;
      end else if (bus.bit_val && ones_r == 3'h6) begin
        bus.abort_stb = 1'b1;
        qn_nxt = '0;
      end else if (bus.bit_val || ones_r != 3'h5) begin
        // A zero after five ones is stuffing and is dropped here
        q_nxt = {bus.bit_val, q_r[6:1]};
        if (qn_r == 3'h7) begin
          bus.data_stb = 1'b1;
        end else begin
          qn_nxt = qn_r + 3'h1;
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_r <= '0;
      ones_r <= '0;
      q_r <= '0;
      qn_r <= '0;
    end else begin
      raw_r <= raw_nxt;
      ones_r <= ones_nxt;
      q_r <= q_nxt;
      qn_r <= qn_nxt;
    end
  end

endmodule // srcs_deframer

// [sim/srcs_sva.sv]
// Port assertions for the SDLC receive channel
`timescale 1ns/1ns
module srcs_sva
  import srcs_pkg::*;
#(
  parameter logic CHAN_ID = 1'b1,
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [SRCS_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rx_clk,
  input wire logic rx_data,
  input wire logic dcd,
  input wire logic dma_ack,
  input wire logic dma_req,
  input wire logic [7:0] dma_data,
  input wire logic irq,
  input wire logic dtr
);
  logic sel_ctl, cmd_rst, ena_wr;
  logic [2:0] ptr_r, ptr_nxt;
  logic auto_r, auto_nxt;
  logic [3:0] ena_r, ena_nxt, low_r, low_nxt;

  // Mirror of pointer, auto enables, interrupt enables, carrier-low time
  always_comb begin
    sel_ctl = addr[0] && !addr[2] && addr[1] == CHAN_ID;
    cmd_rst = wr && sel_ctl && ptr_r == SRCS_PTR_CMD
      && wdata[5:3] == SRCS_CMD_CHAN_RST;
    ena_wr = wr && addr[2] && addr[1:0] == SRCS_AUX_ENABLE;
    ptr_nxt = ptr_r;
    auto_nxt = auto_r;
    ena_nxt = ena_wr ? wdata[3:0] : ena_r;
    low_nxt = dcd ? 4'h0 : (low_r == 4'hF ? low_r : low_r + 4'h1);
    if (wr && sel_ctl) begin
      ptr_nxt = (ptr_r == SRCS_PTR_CMD) ? wdata[2:0] : SRCS_PTR_CMD;
      if (ptr_r == SRCS_PTR_RXC) auto_nxt = wdata[SRCS_RXC_AUTO];
    end
    if (rd && sel_ctl) ptr_nxt = SRCS_PTR_CMD;
    if (cmd_rst) begin
      auto_nxt = 1'b0;
      ena_nxt = 4'h0;
    end
  end

  // Helper registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_r <= SRCS_PTR_CMD;
      auto_r <= 1'b0;
      ena_r <= 4'h0;
      low_r <= 4'h0;
    end else begin
      ptr_r <= ptr_nxt;
      auto_r <= auto_nxt;
      ena_r <= ena_nxt;
      low_r <= low_nxt;
    end
  end

  rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
  other_chan_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd && !addr[2] && addr[1] != CHAN_ID |=> rdata == 8'h00)
    else $error("other channel answered");
  aux_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd && addr[2] && addr[0] |=> rdata == 8'h00)
    else $error("write-only place read nonzero");
  dtr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr && sel_ctl && ptr_r == SRCS_PTR_TXC |=> dtr == $past(wdata[7]))
    else $error("terminal ready not loaded");
  dtr_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr && sel_ctl) |=> $stable(dtr)) else $error("terminal ready moved");
  chan_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_rst |=> !dtr && !irq) else $error("channel reset incomplete");
  dma_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    dma_req && !dma_ack |=> dma_req && $stable(dma_data))
    else $error("dma byte lost before ack");
  irq_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(irq) |-> ena_r != 4'h0) else $error("irq with no enable");
  irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    ena_wr && wdata[3:0] == 4'h0 |=> !irq [*2])
    else $error("masked irq raised");
  carrier_a: assert property (@(posedge clk) disable iff (sys_rst)
    auto_r && low_r > SYNC_STAGES + 5 |-> !$rose(dma_req))
    else $error("byte taken without carrier");
endmodule // srcs_sva

bind srcs_top srcs_sva #(.CHAN_ID(CHAN_ID), .SYNC_STAGES(SYNC_STAGES))
  u_srcs_sva (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .rx_clk(rx_clk), .rx_data(rx_data),
  .dcd(dcd), .dma_ack(dma_ack), .dma_req(dma_req), .dma_data(dma_data),
  .irq(irq), .dtr(dtr));

// [sim/srcs_station.sv]
// Remote SDLC station driving the serial line and carrier detect
`timescale 1ns/1ns
module srcs_station
  import srcs_pkg::*;
(
  output logic rx_clk,
  output logic rx_data,
  output logic dcd
);
  int ones;

  // Line idle: clock stands still between frames
  initial begin
    rx_clk = 1'b0;
    rx_data = 1'b1;
    dcd = 1'b0;
    ones = 0;
  end

  // One bit per 160 ns; data moves only while the clock is low
  task automatic put(input logic b);
    rx_data = b;
    #80 rx_clk = 1'b1;
    #80 rx_clk = 1'b0;
  endtask

  // Boundary pattern, sent raw without zero insertion
  task automatic flag();
    for (int i = 0; i < 8; i++) put(SRCS_RST_FLAG[i]);
    ones = 0;
  endtask

  // Byte LSB first, a zero after five ones keeps it from looking a flag
  task automatic octet(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      put(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask

  // Opening flag, address, two bytes, closing flag
  task automatic frame(input logic [7:0] a, b, c);
    flag();
    octet(a);
    octet(b);
    octet(c);
    flag();
    rx_data = ~rx_data; // Released line must not keep its last level
  endtask

  task automatic carrier(input logic v);
    dcd = v;
  endtask
endmodule // srcs_station

// [sim/srcs_top_bench.sv]
// Self-checking bench for the SDLC receive channel
`timescale 1ns/1ns
module srcs_top_bench
  import srcs_pkg::*;
;
  localparam logic [2:0] CTL = 3'h3;
  localparam logic [2:0] DAT = 3'h2;
  localparam logic [2:0] IST = 3'h4;
  localparam logic [2:0] ICL = 3'h5;
  localparam logic [2:0] IEN = 3'h6;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dma_ack = 1'b0;
  logic [7:0] rdata, dma_data;
  logic dma_req, irq, dtr, rx_clk, rx_data, dcd;
  logic [7:0] dq[$];
  logic [7:0] dexp[6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
  int errors = 0;
  int checked = 0;

  srcs_top u_srcs_top (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_clk(rx_clk),
    .rx_data(rx_data), .dcd(dcd), .dma_ack(dma_ack), .dma_req(dma_req),
    .dma_data(dma_data), .irq(irq), .dtr(dtr));
  srcs_station u_srcs_station (.rx_clk(rx_clk), .rx_data(rx_data),
    .dcd(dcd));

  initial begin
    forever #10 clk = ~clk;
  end

  // DMA side pops each byte one cycle after it is offered
  always @(posedge clk) begin
    if (dma_req === 1'b1 && !dma_ack) begin
      dq.push_back(dma_data);
      dma_ack <= 1'b1;
    end else begin
      dma_ack <= 1'b0;
    end
  end

  task automatic cmp(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] e,
                      input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(n, rdata, e);
  endtask

  // Pointer byte, then the selected register
  task automatic wptr(input logic [7:0] p, d);
    wreg(CTL, p);
    wreg(CTL, d);
  endtask

  // One frame, then time for the synchroniser and pipeline
  task automatic send(input logic [7:0] a, b, c);
    u_srcs_station.frame(a, b, c);
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(IEN, 8'h00, "enable at reset");
    rchk(3'h1, 8'h00, "other channel");
    rchk(3'h7, 8'h00, "unmapped");
    wreg(DAT, 8'h5A);
    wreg(CTL, 8'h18);
    wptr(8'h02, 8'h40);
    wptr(8'h04, 8'h20);
    wptr(8'h15, 8'h80);
    @(negedge clk);
    cmp("dtr", {7'h00, dtr}, 8'h01);
    wptr(8'h03, 8'hFC);
    wptr(8'h06, 8'hA5);
    wptr(8'h07, SRCS_RST_FLAG);
    wptr(8'h11, 8'h0D);
    wreg(CTL, 8'h23);
    wreg(CTL, 8'hFD);
    wreg(IEN, 8'h0F);
    rchk(CTL, 8'h10, "hunting");
    send(8'hA5, 8'h11, 8'h22);
    rchk(IST, 8'h00, "no carrier");
    cmp("dma count", 8'(dq.size()), 8'h00);
    u_srcs_station.carrier(1'b1);
    repeat (10) @(posedge clk);
    rchk(IST, 8'h04, "carrier change");
    wreg(ICL, 8'h0F);
    send(8'h3C, 8'h11, 8'h22);
    rchk(IST, 8'h00, "foreign frame");
    send(8'hA5, 8'h11, 8'h22);
    cmp("irq", {7'h00, irq}, 8'h01);
    rchk(IST, 8'h09, "first char");
    rchk(DAT, 8'hA5, "address");
    wreg(CTL, 8'h02);
    rchk(CTL, 8'h46, "vector");
    rchk(CTL, 8'h0A, "status");
    wreg(ICL, 8'h0F);
    send(8'hA5, 8'h33, 8'h44);
    rchk(IST, 8'h08, "disarmed");
    rchk(DAT, 8'hA5, "address");
    wreg(CTL, 8'h20);
    wreg(ICL, 8'h0F);
    send(SRCS_GLOBAL_ADDR, 8'h55, 8'h66);
    rchk(IST, 8'h09, "rearmed");
    rchk(DAT, SRCS_GLOBAL_ADDR, "global");
    cmp("dma count", 8'(dq.size()), 8'h06);
    foreach (dexp[i]) cmp("dma byte", dq[i], dexp[i]);
    wreg(ICL, 8'h0F);
    wptr(8'h03, 8'hFD);
    rchk(CTL, 8'h18, "hunt again");
    u_srcs_station.carrier(1'b0);
    repeat (10) @(posedge clk);
    @(negedge clk);
    cmp("irq", {7'h00, irq}, 8'h01);
    // Masking every source must drop the line, unmasking restores it
    wreg(IEN, 8'h00);
    @(negedge clk);
    cmp("irq masked", {7'h00, irq}, 8'h00);
    wreg(IEN, 8'h0F);
    @(negedge clk);
    cmp("irq unmasked", {7'h00, irq}, 8'h01);
    wreg(CTL, 8'h18);
    @(negedge clk);
    cmp("irq", {7'h00, irq}, 8'h00);
    cmp("dtr", {7'h00, dtr}, 8'h00);
    rchk(IEN, 8'h00, "enable cleared");
    summarize();
  end
endmodule // srcs_top_bench
